// *** core/bus_sequencer.sv ***
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ebs_map.svh"
module bus_sequencer #(
  parameter int NUM_CS = 4
) (
  // System clock, reset and link clock
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic LINK_CLK_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // External bus
  output logic [23:0] ADDR_O,
  output logic ALE_O,
  output logic [NUM_CS-1:0] CS_B_O,
  output logic RD_B_O,
  output logic WR_B_O,
  output logic [15:0] DATA_O,
  output logic DATA_OE_B_O,
  input wire logic [15:0] DATA_I,
  input wire logic READY_I,
  output logic BUS_REF_CLK_O
);
  localparam int CSW = (NUM_CS > 1) ? $clog2(NUM_CS) : 1;

  // ==========================================
  // Input synchronisers
  logic rdy_link;
  logic rdy_s;
  logic [15:0] data_s;

  // Ready is first cleaned up on the partner's clock, then crossed as a level
  level_sync #(.W(1)) u_rdy_link (.clk_i(LINK_CLK_I), .rst_b_i(RST_B_I), .d_i(READY_I), .q_o(rdy_link));
  level_sync #(.W(1)) u_rdy_sys (.clk_i(CLOCK_I), .rst_b_i(RST_B_I), .d_i(rdy_link), .q_o(rdy_s));
  level_sync #(.W(16)) u_data (.clk_i(CLOCK_I), .rst_b_i(RST_B_I), .d_i(DATA_I), .q_o(data_s));

  // ==========================================
  // Registers
  logic [`CFG_W-1:0] cfg_q [NUM_CS];
  logic [1:0] ctrl_q;
  logic [23:0] addr_reg_q;
  logic [15:0] wdata_reg_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic start;

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++)
    begin : g_cfg
      always_ff @(posedge CLOCK_I or negedge RST_B_I)
      begin
        if (!RST_B_I)
          cfg_q[g] <= `CFG_RST;
        else if (REG_WR_I && REG_ADDR_I == `OFS_CFG0 + 8'(4 * g))
          cfg_q[g] <= REG_WDATA_I[`CFG_W-1:0];
      end
    end
  endgenerate

  // ==========================================
  // Sequencer state
  ebs_pkg::phase_t ph_q;
  ebs_pkg::phase_t ph_d;
  logic [`CFG_W-1:0] cur_q;
  logic [`CFG_W-1:0] cur_d;
  logic [CSW-1:0] cs_q;
  logic [CSW-1:0] cs_d;
  logic [CSW-1:0] last_cs_q;
  logic [CSW-1:0] last_cs_d;
  logic wr_q;
  logic wr_d;
  logic [5:0] ab_len;
  phase_if pif ();

  phase_timer u_timer (.clk_i(CLOCK_I), .rst_b_i(RST_B_I), .pif(pif));

  assign start = REG_WR_I && REG_ADDR_I == `OFS_REQ && ph_q == ebs_pkg::PH_IDLE;

  // Successor of a phase; zero-length phases fall out
  function automatic ebs_pkg::phase_t succ(input ebs_pkg::phase_t p, input logic [`CFG_W-1:0] c);
    succ = ebs_pkg::PH_IDLE;
    case (p)
      ebs_pkg::PH_AB:
      begin
        if (c[`CFG_CMD_LO+:2] != 2'b00)
          succ = ebs_pkg::PH_CMD;
        else if (c[`CFG_WSU])
          succ = ebs_pkg::PH_WSU;
        else
          succ = ebs_pkg::PH_ACC;
      end
      ebs_pkg::PH_CMD:
        succ = c[`CFG_WSU] ? ebs_pkg::PH_WSU : ebs_pkg::PH_ACC;
      ebs_pkg::PH_WSU:
        succ = ebs_pkg::PH_ACC;
      ebs_pkg::PH_ACC:
        succ = (c[`CFG_HOLD_LO+:2] != 2'b00) ? ebs_pkg::PH_HOLD : ebs_pkg::PH_IDLE;
      default:
        succ = ebs_pkg::PH_IDLE;
    endcase
  endfunction

  function automatic logic [5:0] plen(input ebs_pkg::phase_t p, input logic [`CFG_W-1:0] c);
    case (p)
      ebs_pkg::PH_CMD:
        plen = {4'h0, c[`CFG_CMD_LO+:2]};
      ebs_pkg::PH_WSU:
        plen = 6'h01;
      ebs_pkg::PH_ACC:
        plen = {1'b0, c[`CFG_ACC_LO+:5]} + 6'h01;
      ebs_pkg::PH_HOLD:
        plen = {4'h0, c[`CFG_HOLD_LO+:2]};
      default:
        plen = 6'h01;
    endcase
  endfunction

  always_comb
  begin
    ph_d = ph_q;
    cur_d = cur_q;
    cs_d = cs_q;
    last_cs_d = last_cs_q;
    wr_d = wr_q;
    rdata_d = rdata_q;
    pif.load = 1'b0;
    pif.len = 6'h01;
    ab_len = 6'h00;
    if (start)
    begin
      cs_d = REG_WDATA_I[`REQ_CS_LO+:CSW];
      wr_d = REG_WDATA_I[`REQ_WRITE];
      cur_d = cfg_q[cs_d];
      // Window change stretches address setup
      ab_len = {5'h00, cur_d[`CFG_AB]} + 6'h01;
      if (cs_d != last_cs_q)
        ab_len = ab_len + {4'h0, cur_d[`CFG_EXT_LO+:2]};
      last_cs_d = cs_d;
      ph_d = ebs_pkg::PH_AB;
      pif.load = 1'b1;
      pif.len = ab_len;
    end
    else if (ph_q != ebs_pkg::PH_IDLE && pif.min_done)
    begin
      // Ready only counts once the minimum access length is spent
      if (!(ph_q == ebs_pkg::PH_ACC && cur_q[`CFG_RDY] && !rdy_s))
      begin
        ph_d = succ(ph_q, cur_q);
        pif.load = 1'b1;
        pif.len = plen(ph_d, cur_q);
        if (ph_q == ebs_pkg::PH_ACC && !wr_q)
          rdata_d = data_s;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ph_q <= ebs_pkg::PH_IDLE;
      cur_q <= `CFG_RST;
      cs_q <= '0;
      last_cs_q <= '0;
      wr_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ph_q <= ph_d;
      cur_q <= cur_d;
      cs_q <= cs_d;
      last_cs_q <= last_cs_d;
      wr_q <= wr_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // Software registers and read port
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ctrl_q <= 2'b00;
      addr_reg_q <= 24'h00_0000;
      wdata_reg_q <= 16'h0000;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      if (REG_WR_I && REG_ADDR_I == `OFS_CTRL)
        ctrl_q <= REG_WDATA_I[1:0];
      if (REG_WR_I && REG_ADDR_I == `OFS_ADDR)
        addr_reg_q <= REG_WDATA_I[23:0];
      if (REG_WR_I && REG_ADDR_I == `OFS_WDATA)
        wdata_reg_q <= REG_WDATA_I[15:0];
      rd_q <= rd_d;
    end
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (REG_RD_I)
    begin
      for (int i = 0; i < NUM_CS; i++)
        if (REG_ADDR_I == `OFS_CFG0 + 8'(4 * i))
          rd_d = {{(32 - `CFG_W){1'b0}}, cfg_q[i]};
      case (REG_ADDR_I)
        `OFS_CTRL:
          rd_d = {30'h0, ctrl_q};
        `OFS_ADDR:
          rd_d = {8'h00, addr_reg_q};
        `OFS_WDATA:
          rd_d = {16'h0000, wdata_reg_q};
        `OFS_RDATA:
          rd_d = {16'h0000, rdata_q};
        `OFS_STATUS:
          rd_d = {28'h0, ph_q, ph_q != ebs_pkg::PH_IDLE};
        default:
          ;
      endcase
    end
  end

  assign REG_RDATA_O = rd_q;

  // ==========================================
  // Pin registers, computed from the next phase so pins line up with it
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ADDR_O <= 24'h00_0000;
      ALE_O <= 1'b0;
      CS_B_O <= '1;
      RD_B_O <= 1'b1;
      WR_B_O <= 1'b1;
      DATA_O <= 16'h0000;
      DATA_OE_B_O <= 1'b1;
    end
    else
    begin
      if (start)
        ADDR_O <= addr_reg_q;
      ALE_O <= ph_d == ebs_pkg::PH_AB;
      CS_B_O <= (ph_d == ebs_pkg::PH_IDLE) ? '1 : ~(NUM_CS'(1) << cs_d);
      RD_B_O <= !(ph_d == ebs_pkg::PH_ACC && !wr_d);
      WR_B_O <= !(ph_d == ebs_pkg::PH_ACC && wr_d);
      DATA_O <= wdata_reg_q;
      DATA_OE_B_O <= !(wr_d && (ph_d == ebs_pkg::PH_WSU || ph_d == ebs_pkg::PH_ACC || ph_d == ebs_pkg::PH_HOLD));
    end
  end

  // ==========================================
  // Reference clock: two toggles, one per edge, give one period per cycle
  logic tog_p_q;
  logic tog_n_q;
  logic ref_en_q;

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      tog_p_q <= 1'b0;
      ref_en_q <= 1'b0;
    end
    else
    begin
      tog_p_q <= !tog_p_q;
      ref_en_q <= ctrl_q[`CTRL_SRC_SYS] && ctrl_q[`CTRL_HS_DRV];
    end
  end

  always_ff @(negedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      tog_n_q <= 1'b0;
    else
      tog_n_q <= tog_p_q;
  end

  // High from rising to falling edge while enabled
  assign BUS_REF_CLK_O = ref_en_q && (tog_p_q ^ tog_n_q);

  // ==========================================
  // Checks
  logic [6:0] cyc_q;

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      cyc_q <= 7'h00;
    else if (ph_d != ph_q || pif.load)
      cyc_q <= 7'h00;
    else if (cyc_q != 7'h7F)
      cyc_q <= cyc_q + 7'h01;
  end

  a_phase_order: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    ph_q == ebs_pkg::PH_AB && ph_d != ebs_pkg::PH_AB |-> ph_d inside {ebs_pkg::PH_CMD, ebs_pkg::PH_WSU, ebs_pkg::PH_ACC})
    else $error("address setup left to a wrong phase");
  a_cfg_taken: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    start |=> cur_q == cfg_q[cs_q])
    else $error("timing configuration not taken at start");
  a_ab_length: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    ph_q == ebs_pkg::PH_AB && ph_d != ebs_pkg::PH_AB |-> cyc_q >= 7'h00 && cyc_q <= 7'h04)
    else $error("address setup length out of range");
  a_acc_min: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    ph_q == ebs_pkg::PH_ACC && ph_d != ebs_pkg::PH_ACC |-> cyc_q + 7'h01 >= {2'b00, cur_q[`CFG_ACC_LO+:5]} + 7'h01)
    else $error("access phase shorter than programmed");
  a_ready_stretch: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    ph_q == ebs_pkg::PH_ACC && cur_q[`CFG_RDY] && !rdy_s |=> ph_q == ebs_pkg::PH_ACC)
    else $error("access ended without ready");
  a_read_capture: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    $past(ph_q) == ebs_pkg::PH_ACC && ph_q != ebs_pkg::PH_ACC && !wr_q |-> rdata_q == $past(data_s))
    else $error("read data not captured at strobe end");
  a_strobe_gap: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    $fell(RD_B_O) || $fell(WR_B_O) |-> $past(CS_B_O) != '1)
    else $error("strobe edge too close to chip select edge");
  a_ref_enable: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    ctrl_q == 2'b11 |=> ref_en_q ##1 tog_p_q != $past(tog_p_q))
    else $error("reference clock not running");
  a_skip_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    ph_q == ebs_pkg::PH_CMD |-> cur_q[`CFG_CMD_LO+:2] != 2'b00)
    else $error("zero length command delay entered");
  a_ready_late: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    ph_q == ebs_pkg::PH_ACC && cur_q[`CFG_RDY] && rdy_s && pif.min_done |=> ph_q != ebs_pkg::PH_ACC)
    else $error("access not ended on ready");
endmodule
`default_nettype wire

// *** core/ebs_map.svh ***
`ifndef EBS_MAP_SVH
`define EBS_MAP_SVH
// ==========================================
// Register offsets
`define OFS_CFG0 8'h00
`define OFS_CTRL 8'h10
`define OFS_REQ 8'h14
`define OFS_ADDR 8'h18
`define OFS_WDATA 8'h1C
`define OFS_RDATA 8'h20
`define OFS_STATUS 8'h24
// ==========================================
// Timing configuration fields
`define CFG_AB 0
`define CFG_EXT_LO 1
`define CFG_CMD_LO 3
`define CFG_WSU 5
`define CFG_ACC_LO 6
`define CFG_HOLD_LO 11
`define CFG_RDY 13
`define CFG_W 14
`define CFG_RST 14'h07C0
// ==========================================
// Control and request fields
`define CTRL_SRC_SYS 0
`define CTRL_HS_DRV 1
`define REQ_WRITE 0
`define REQ_CS_LO 1
// ==========================================
// Timing
`define SYS_PERIOD_PS 20000
`define MIN_EDGE_PS 12500
`define MIN_EDGE_CYC ((`MIN_EDGE_PS + `SYS_PERIOD_PS - 1) / `SYS_PERIOD_PS)
`define MAX_SYS_MHZ 80
`define SYS_MHZ 50
`endif

// *** core/ebs_pkg.sv ***
package ebs_pkg;
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b000,
    PH_AB = 3'b001,
    PH_CMD = 3'b010,
    PH_WSU = 3'b011,
    PH_ACC = 3'b100,
    PH_HOLD = 3'b101
  } phase_t;
endpackage

// *** core/phase_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  logic load;
  logic [5:0] len;
  logic min_done;
  modport seq (output load, output len, input min_done);
  modport tmr (input load, input len, output min_done);
endinterface
`default_nettype wire

// *** core/level_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// *** core/phase_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  phase_if.tmr pif
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (pif.load)
      cnt_d = pif.len;
    else if (cnt_q != 6'h00)
      cnt_d = cnt_q - 6'h01;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_q <= 6'h00;
    else
      cnt_q <= cnt_d;
  end

  // Last cycle of the loaded length, or already past it
  assign pif.min_done = (cnt_q <= 6'h01);
endmodule
`default_nettype wire

// *** tb/ext_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // Link side
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] wait_i,
  // Bus pins
  input wire logic [23:0] addr_i,
  input wire logic [3:0] cs_b_i,
  input wire logic wr_b_i,
  input wire logic [15:0] data_i,
  input wire logic data_oe_b_i,
  output logic [15:0] data_o,
  output logic ready_o
);
  logic [15:0] mem_q [16];
  logic [15:0] drv_q;
  logic [7:0] cnt_q;
  logic sel_q;
  logic sel;
  logic rd_sel;
  assign sel = (cs_b_i != 4'hF);
  assign rd_sel = sel && wr_b_i && data_oe_b_i;
  assign data_o = drv_q;
  // Low from the moment of selection when wait_i is nonzero, so no stale high reaches the synchroniser
  assign ready_o = (cnt_q == 8'h00) && !(sel && !sel_q && wait_i != 8'h00);
  always @(posedge wr_b_i)
    mem_q[addr_i[3:0]] = data_i;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sel_q <= 1'b0;
      cnt_q <= 8'h00;
      drv_q <= 16'h5A5A;
    end
    else
    begin
      sel_q <= sel;
      if (sel && !sel_q)
        cnt_q <= wait_i;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
      // Released bus keeps changing instead of holding the last word
      drv_q <= rd_sel ? mem_q[addr_i[3:0]] : ~drv_q;
    end
  end
endmodule
`default_nettype wire

// *** tb/external_bus_cycle_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_cycle_sequencer_test;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] wt = 8'h00;
  logic [31:0] rdat;
  logic [31:0] v;
  logic [23:0] addr;
  logic [3:0] cs_b;
  logic [15:0] dout;
  logic [15:0] din;
  logic ale, rd_b, wr_b, oe_b, rdy, rclk, a, b;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int na, nc, ns, no;

  always #10 clk = ~clk;
  always #15 lclk = ~lclk;

  bus_sequencer u_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .LINK_CLK_I(lclk),
    .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(we), .REG_RD_I(re), .REG_RDATA_O(rdat),
    .ADDR_O(addr), .ALE_O(ale), .CS_B_O(cs_b), .RD_B_O(rd_b), .WR_B_O(wr_b),
    .DATA_O(dout), .DATA_OE_B_O(oe_b), .DATA_I(din), .READY_I(rdy), .BUS_REF_CLK_O(rclk));

  ext_mem_model u_mem (.clk_i(lclk), .rst_b_i(rst_b), .wait_i(wt), .addr_i(addr),
    .cs_b_i(cs_b), .wr_b_i(wr_b), .data_i(dout), .data_oe_b_i(oe_b), .data_o(din), .ready_o(rdy));

  // =====
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    ra <= ad;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] ad);
    ra <= ad;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    v = rdat;
    @(posedge clk);
  endtask

  // Counts phase cycles of one access; dbl repeats a request while busy
  task automatic run_acc(input logic [31:0] req, input logic dbl, input logic [3:0] csx);
    na = 0;
    nc = 0;
    ns = 0;
    no = 0;
    ra <= 8'h14;
    wd <= req;
    we <= 1'b1;
    @(posedge clk);
    we <= dbl;
    wd <= 32'h0000_0000;
    for (int k = 0; k < 200; k++)
    begin
      #1;
      if (cs_b === 4'hF)
        break;
      na += int'(ale === 1'b1);
      nc += int'(cs_b === csx);
      ns += int'(rd_b === 1'b0 || wr_b === 1'b0);
      no += int'(oe_b === 1'b0);
      @(posedge clk);
      we <= 1'b0;
    end
    repeat (5) @(posedge clk);
    #1;
    chk("idle_cs", cs_b, 4'hF);
    @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // =====
  // Scenarios
  task automatic t_write;
    wr(8'h04, 32'h0000_193F);
    wr(8'h18, 32'h0012_3456);
    wr(8'h1C, 32'h0000_BEEF);
    run_acc(32'h0000_0003, 1'b1, 4'b1101);
    chk("ale", na, 5);
    chk("cs", nc, 17);
    chk("strobe", ns, 5);
    chk("oe", no, 9);
    chk("addr", addr, 24'h12_3456);
    chk("mem", u_mem.mem_q[6], 16'hBEEF);
    run_acc(32'h0000_0003, 1'b0, 4'b1101);
    chk("ale_same", na, 2);
    $display("test write done");
  endtask

  task automatic t_zero;
    wr(8'h00, 32'h0000_00C0);
    run_acc(32'h0000_0000, 1'b0, 4'b1110);
    chk("ale0", na, 1);
    chk("cs0", nc, 5);
    chk("strobe0", ns, 4);
    chk("oe0", no, 0);
    rd(8'h20);
    chk("rdata", v[15:0], 16'hBEEF);
    $display("test zero done");
  endtask

  task automatic t_ready;
    wr(8'h08, 32'h0000_20C0);
    wt <= 8'h0C;
    run_acc(32'h0000_0004, 1'b0, 4'b1011);
    chk("stretch", 32'(ns >= 16 && ns <= 28), 1);
    wt <= 8'h00;
    run_acc(32'h0000_0004, 1'b0, 4'b1011);
    chk("min_acc", ns, 4);
    rd(8'h20);
    chk("rdata_rdy", v[15:0], 16'hBEEF);
    $display("test ready done");
  endtask

  task automatic t_regs;
    rd(8'h04);
    chk("cfg1", v, 32'h0000_193F);
    rd(8'h0C);
    chk("cfg3", v, 32'h0000_07C0);
    rd(8'h24);
    chk("status", v, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk("unmapped", v, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_refclk;
    wr(8'h10, 32'h0000_0003);
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      #5;
      a = rclk;
      #10;
      b = rclk;
      chk("ref_toggle", 32'(a ^ b), 1);
      @(posedge clk);
    end
    wr(8'h10, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #5;
    chk("ref_off_hi", rclk, 1'b0);
    #10;
    chk("ref_off_lo", rclk, 1'b0);
    @(posedge clk);
    $display("test refclk done");
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (11) @(posedge clk);
    #1;
    chk("rst_cs", cs_b, 4'hF);
    chk("rst_str", {rd_b, wr_b, oe_b, ale, rclk}, 5'b11100);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_write();
    t_zero();
    t_ready();
    t_regs();
    t_refclk();
    tally_and_finish();
  end
endmodule
`default_nettype wire
